// ---- t16oc_top.sv ----
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps

// Function
// (R1) Compare full count to each value continuously
// (R2) Match flag set on the next tick
// (R3) Enabled flag requests irq, cleared on service
// (R4) Writing one clears a match flag
// (R5) Channel A value can set counter TOP
// (R6) Compare value buffered only in PWM modes
// (R7) Buffer loads active register at TOP
// (R8) CPU reaches buffer or active register per mode
// (R9) Compare high byte read directly, not latch
// (R10) High byte to latch, low write loads all
// (R11) Force strobe acts like match, no flag
// (R12) Count write blocks matches on next tick
// (R13) Software avoids writing count equal to TOP
// (R14) Output state kept across mode changes
// (R15) Action bits unbuffered, used at next match
// (R16) Reset clears output state to zero
// (R17) Output state overrides port when routed
// (R18) Action zero leaves output state unchanged
// (R19) Action bits never alter counting sequence
// (R20) Normal mode counts up, wraps, writable anytime
// (R21) Overflow flag set as count wraps
// (R22) CPU count write beats clear or count
// (R23) Clock select zero stops timer clock
// (R24) Non-PWM actions toggle, clear, set
module t16oc_top import t16oc_pkg::*; #(
    parameter int CNT_W = 16
) (
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              timerTick,
    input  wire logic [2:0]        irqServiced,
    output logic [2:0]             irqRequest,
    input  wire logic [NUM_CH-1:0] portData,
    input  wire logic [NUM_CH-1:0] portDir,
    output logic [NUM_CH-1:0]      compareOutputPin,
    output logic [NUM_CH-1:0]      compareOutputPinOe
);

    typedef struct packed {
        t16oc_phase_t                   phase;
        logic                           ready;
        logic                           slverr;
        logic [31:0]                    rdata;
        logic [3:0]                     waveformModeSelect;
        logic [2:0]                     clockSourceSelect;
        logic [NUM_CH-1:0][1:0]         outputActionBits;
        logic [2:0]                     irqEnable;
        logic [NUM_CH-1:0]              pinRouteEnable;
        logic [7:0]                     highLatch;
        logic [CNT_W-1:0]               timerCount;
        logic [NUM_CH-1:0][CNT_W-1:0]   compareActive;
        logic [NUM_CH-1:0][CNT_W-1:0]   compareBuffer;
        logic [2:0]                     flags;
        logic                           matchBlock;
        logic [NUM_CH-1:0]              compareOutputState;
        logic [NUM_CH-1:0]              pinOut;
        logic [NUM_CH-1:0]              pinOe;
        logic [2:0]                     irq;
    } t16oc_state_t;

    t16oc_state_t st_q;
    t16oc_state_t st_d;

    function automatic logic isPwm(input logic [3:0] mode);
        isPwm = !(mode == MODE_NORMAL || mode == MODE_CTC_CMPA || mode == MODE_CTC_CAP);
    endfunction

    function automatic logic [CNT_W-1:0] topOf(input logic [3:0] mode,
                                               input logic [CNT_W-1:0] cmpA);
        case (mode)
            MODE_FAST8:    topOf = TOP_FIX8;
            MODE_FAST9:    topOf = TOP_FIX9;
            MODE_FAST10:   topOf = TOP_FIX10;
            MODE_CTC_CMPA,
            MODE_PFC_CMPA,
            MODE_PC_CMPA,
            MODE_FAST_A:   topOf = cmpA;
            default:       topOf = CNT_MAX;
        endcase
    endfunction

    function automatic logic applyAction(input logic [1:0] act, input logic cur);
        case (act)
            ACT_TOGGLE: applyAction = ~cur;
            ACT_CLEAR:  applyAction = 1'b0;
            ACT_SET:    applyAction = 1'b1;
            default:    applyAction = cur;
        endcase
    endfunction

    logic                   accessDone;
    logic                   wrDone;
    logic                   pwmMode;
    logic                   tickEn;
    logic                   countWrite;
    logic [CNT_W-1:0]       topValue;
    logic                   atTop;
    logic [NUM_CH-1:0]      hit;
    logic [NUM_CH-1:0]      forceHit;
    logic [2:0]             setEv;
    logic [2:0]             clrEv;
    logic [31:0]            readValue;
    logic                   addrOk;

    always_comb begin
        st_d       = st_q;
        accessDone = psel && penable && st_q.ready;
        wrDone     = accessDone && pwrite;
        pwmMode    = isPwm(st_q.waveformModeSelect);
        // (R23) Stopped clock
        tickEn     = timerTick && (st_q.clockSourceSelect != 3'h0);
        countWrite = wrDone && (paddr == OFS_COUNT_LO);
        // (R5) TOP from A
        topValue   = topOf(st_q.waveformModeSelect, st_q.compareActive[0]);
        atTop      = (st_q.timerCount == topValue);
        setEv      = 3'b000;
        clrEv      = 3'b000;
        readValue  = 32'h0000_0000;
        addrOk     = 1'b1;

        case (paddr)
            OFS_CTRL: begin
                readValue[CTRL_MODE_LSB +: 4]  = st_q.waveformModeSelect;
                readValue[CTRL_CLK_LSB +: 3]   = st_q.clockSourceSelect;
                readValue[CTRL_ACTA_LSB +: 2]  = st_q.outputActionBits[0];
                readValue[CTRL_ACTB_LSB +: 2]  = st_q.outputActionBits[1];
                readValue[CTRL_IRQEN_LSB +: 3] = st_q.irqEnable;
                readValue[CTRL_ROUTE_LSB +: 2] = st_q.pinRouteEnable;
            end
            OFS_FLAGS: begin
                readValue[2:0]                        = st_q.flags;
                readValue[FLAG_OCST_LSB +: NUM_CH]    = st_q.compareOutputState;
            end
            OFS_FORCE:    readValue = 32'h0000_0000;
            OFS_COUNT_LO: readValue[7:0] = st_q.timerCount[7:0];
            OFS_COUNT_HI: readValue[7:0] = st_q.highLatch;
            // (R8) (R9) Direct reads
            OFS_CMPA_LO:  readValue[7:0] = pwmMode ? st_q.compareBuffer[0][7:0]
                                                   : st_q.compareActive[0][7:0];
            OFS_CMPA_HI:  readValue[7:0] = pwmMode ? st_q.compareBuffer[0][15:8]
                                                   : st_q.compareActive[0][15:8];
            OFS_CMPB_LO:  readValue[7:0] = pwmMode ? st_q.compareBuffer[1][7:0]
                                                   : st_q.compareActive[1][7:0];
            OFS_CMPB_HI:  readValue[7:0] = pwmMode ? st_q.compareBuffer[1][15:8]
                                                   : st_q.compareActive[1][15:8];
            default:      addrOk = 1'b0;
        endcase

        // Bus phase: one wait state, then the answer
        case (st_q.phase)
            PH_IDLE: begin
                if (psel && penable) begin
                    st_d.phase  = PH_RESP;
                    st_d.ready  = 1'b1;
                    st_d.slverr = !addrOk;
                    st_d.rdata  = pwrite ? 32'h0000_0000 : readValue;
                    // Latch captured with the data so both halves match
                    if (!pwrite && addrOk && paddr == OFS_COUNT_LO) begin
                        st_d.highLatch = st_q.timerCount[15:8];
                    end
                end
            end
            PH_RESP: begin
                st_d.phase  = PH_IDLE;
                st_d.ready  = 1'b0;
                st_d.slverr = 1'b0;
            end
            default: begin
                st_d.phase = PH_IDLE;
                st_d.ready = 1'b0;
            end
        endcase

        if (wrDone) begin
            case (paddr)
                OFS_CTRL: begin
                    // (R14) (R15) Mode and actions apply directly
                    st_d.waveformModeSelect  = pwdata[CTRL_MODE_LSB +: 4];
                    st_d.clockSourceSelect   = pwdata[CTRL_CLK_LSB +: 3];
                    st_d.outputActionBits[0] = pwdata[CTRL_ACTA_LSB +: 2];
                    st_d.outputActionBits[1] = pwdata[CTRL_ACTB_LSB +: 2];
                    st_d.irqEnable           = pwdata[CTRL_IRQEN_LSB +: 3];
                    st_d.pinRouteEnable      = pwdata[CTRL_ROUTE_LSB +: 2];
                end
                // (R4) Write one to clear
                OFS_FLAGS: clrEv = pwdata[2:0];
                // (R10) High byte goes only to the latch
                OFS_COUNT_HI,
                OFS_CMPA_HI,
                OFS_CMPB_HI: st_d.highLatch = pwdata[7:0];
                OFS_CMPA_LO,
                OFS_CMPB_LO: begin
                    for (int c = 0; c < NUM_CH; c++) begin
                        if (paddr == (c == 0 ? OFS_CMPA_LO : OFS_CMPB_LO)) begin
                            // (R6) (R8) (R10) Buffer always, active when unbuffered
                            st_d.compareBuffer[c] = {st_q.highLatch, pwdata[7:0]};
                            if (!pwmMode) begin
                                st_d.compareActive[c] = {st_q.highLatch, pwdata[7:0]};
                            end
                        end
                    end
                end
                default: ;
            endcase
        end

        // (R3) Service acknowledge
        clrEv = clrEv | irqServiced;

        // (R12) Block spans the next tick, even if stopped
        if (countWrite) begin
            st_d.matchBlock = 1'b1;
        end else if (tickEn) begin
            st_d.matchBlock = 1'b0;
        end

        // (R22) (R20) CPU write wins over counting
        if (countWrite) begin
            st_d.timerCount = {st_q.highLatch, pwdata[7:0]};
        end else if (tickEn) begin
            // (R19) Sequence depends on mode and TOP only
            if (st_q.waveformModeSelect != MODE_NORMAL && atTop) begin
                st_d.timerCount = CNT_BOT;
            end else begin
                st_d.timerCount = st_q.timerCount + 16'h0001;
            end
        end

        // (R21) Overflow as count returns to bottom
        if (tickEn && !countWrite && atTop) begin
            setEv[FLAG_OVF] = 1'b1;
        end

        for (int c = 0; c < NUM_CH; c++) begin
            // (R1) (R12) Comparator, blocked after count write
            hit[c]      = tickEn && !st_q.matchBlock
                          && (st_q.timerCount == st_q.compareActive[c]);
            // (R11) Force only outside PWM
            forceHit[c] = wrDone && (paddr == OFS_FORCE) && pwdata[c] && !pwmMode;
            // (R2) Flag appears on the edge after the match tick
            setEv[c]    = hit[c];
            if (!pwmMode) begin
                // (R24) (R18) (R11) Toggle, clear or set
                if (hit[c] || forceHit[c]) begin
                    st_d.compareOutputState[c] =
                        applyAction(st_q.outputActionBits[c], st_q.compareOutputState[c]);
                end
            end else begin
                // PWM: inverse action on match, the action itself at TOP
                if (hit[c] && st_q.outputActionBits[c] != ACT_NONE
                    && st_q.outputActionBits[c] != ACT_TOGGLE) begin
                    st_d.compareOutputState[c] = (st_q.outputActionBits[c] == ACT_CLEAR);
                end else if (tickEn && !countWrite && atTop
                             && st_q.outputActionBits[c] != ACT_NONE
                             && st_q.outputActionBits[c] != ACT_TOGGLE) begin
                    st_d.compareOutputState[c] = (st_q.outputActionBits[c] == ACT_SET);
                end
                // (R7) Buffer transfer at TOP
                if (tickEn && !countWrite && atTop) begin
                    st_d.compareActive[c] = st_q.compareBuffer[c];
                end
            end
            // (R17) Port override when routed
            st_d.pinOut[c] = (st_q.outputActionBits[c] != ACT_NONE && st_q.pinRouteEnable[c])
                             ? st_d.compareOutputState[c] : portData[c];
            st_d.pinOe[c]  = portDir[c];
        end

        // (R4) Set wins over clear
        st_d.flags = (st_q.flags & ~clrEv) | setEv;
        // (R3) Request from enabled flags
        st_d.irq   = st_d.flags & st_d.irqEnable;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_q.phase              <= PH_IDLE;
            st_q.ready              <= 1'b0;
            st_q.slverr             <= 1'b0;
            st_q.rdata              <= RST_RDATA;
            st_q.waveformModeSelect <= RST_MODE;
            st_q.clockSourceSelect  <= RST_CLKSEL;
            st_q.outputActionBits   <= '0;
            st_q.irqEnable          <= 3'b000;
            st_q.pinRouteEnable     <= '0;
            st_q.highLatch          <= RST_TEMP;
            st_q.timerCount         <= RST_COUNT;
            st_q.compareActive      <= {NUM_CH{RST_CMP}};
            st_q.compareBuffer      <= {NUM_CH{RST_CMP}};
            st_q.flags              <= 3'b000;
            st_q.matchBlock         <= 1'b0;
            // (R16) Output state clears on reset
            st_q.compareOutputState <= '0;
            st_q.pinOut             <= '0;
            st_q.pinOe              <= '0;
            st_q.irq                <= 3'b000;
        end else begin
            st_q <= st_d;
        end
    end

    assign pready             = st_q.ready;
    assign prdata             = st_q.rdata;
    assign pslverr            = st_q.slverr;
    assign irqRequest         = st_q.irq;
    assign compareOutputPin   = st_q.pinOut;
    assign compareOutputPinOe = st_q.pinOe;

    // Checks
    property p_match_flag;
        @(posedge sys_clk) disable iff (reset)
        hit[0] |=> st_q.flags[FLAG_MATCHA];
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("match flag not set"); // (R2)

    property p_block;
        @(posedge sys_clk) disable iff (reset)
        countWrite ##1 !tickEn ##1 (tickEn && !st_q.flags[FLAG_MATCHA] && clrEv == 3'b000
            && st_q.timerCount == st_q.compareActive[0]) |=> !st_q.flags[FLAG_MATCHA];
    endproperty
    a_block: assert property (p_block) else $error("match not blocked"); // (R12)

    property p_w1c;
        @(posedge sys_clk) disable iff (reset)
        (clrEv[FLAG_MATCHA] && !setEv[FLAG_MATCHA]) |=> !st_q.flags[FLAG_MATCHA];
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared"); // (R4)

    property p_irq;
        @(posedge sys_clk) disable iff (reset)
        (hit[0] && st_q.irqEnable[0] && !wrDone) |=> irqRequest[0];
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing"); // (R3)

    property p_force;
        @(posedge sys_clk) disable iff (reset)
        (forceHit[0] && !hit[0] && clrEv == 3'b000 && st_q.outputActionBits[0] == ACT_TOGGLE)
        |=> (st_q.compareOutputState[0] != $past(st_q.compareOutputState[0]))
            && st_q.flags[FLAG_MATCHA] == $past(st_q.flags[FLAG_MATCHA]);
    endproperty
    a_force: assert property (p_force) else $error("force wrong"); // (R11)

    property p_wrap;
        @(posedge sys_clk) disable iff (reset)
        (tickEn && !countWrite && st_q.waveformModeSelect == MODE_NORMAL
         && st_q.timerCount == CNT_MAX)
        |=> st_q.timerCount == CNT_BOT && st_q.flags[FLAG_OVF];
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap or overflow wrong"); // (R21)

    property p_cpu_wins;
        @(posedge sys_clk) disable iff (reset)
        countWrite |=> st_q.timerCount == {$past(st_q.highLatch), $past(pwdata[7:0])};
    endproperty
    a_cpu_wins: assert property (p_cpu_wins) else $error("count write lost"); // (R22)

    property p_buffered;
        @(posedge sys_clk) disable iff (reset)
        (pwmMode && !(tickEn && !countWrite && atTop)) |=> $stable(st_q.compareActive);
    endproperty
    a_buffered: assert property (p_buffered) else $error("active changed early"); // (R7)

    property p_stopped;
        @(posedge sys_clk) disable iff (reset)
        (st_q.clockSourceSelect == 3'h0 && !countWrite) |=> $stable(st_q.timerCount);
    endproperty
    a_stopped: assert property (p_stopped) else $error("count moved while stopped"); // (R23)

    property p_override;
        @(posedge sys_clk) disable iff (reset)
        (st_q.outputActionBits[1] != ACT_NONE && st_q.pinRouteEnable[1])
        ##1 $stable(st_q.outputActionBits[1]) && $stable(st_q.pinRouteEnable[1])
        |-> compareOutputPin[1] == st_q.compareOutputState[1];
    endproperty
    a_override: assert property (p_override) else $error("pin not overridden"); // (R17)

    c_match:    cover property (@(posedge sys_clk) disable iff (reset) hit[1]);
    c_force:    cover property (@(posedge sys_clk) disable iff (reset) forceHit[0]);
    c_overflow: cover property (@(posedge sys_clk) disable iff (reset) setEv[FLAG_OVF]);
    c_pwm_load: cover property (@(posedge sys_clk) disable iff (reset)
                               pwmMode && tickEn && atTop);

endmodule

// ---- t16oc_pkg.sv ----
package t16oc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_FLAGS    = 8'h04;
    localparam logic [7:0] OFS_FORCE    = 8'h08;
    localparam logic [7:0] OFS_COUNT_LO = 8'h0C;
    localparam logic [7:0] OFS_COUNT_HI = 8'h10;
    localparam logic [7:0] OFS_CMPA_LO  = 8'h14;
    localparam logic [7:0] OFS_CMPA_HI  = 8'h18;
    localparam logic [7:0] OFS_CMPB_LO  = 8'h1C;
    localparam logic [7:0] OFS_CMPB_HI  = 8'h20;

    // Control register fields
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_CLK_LSB   = 4;
    localparam int CTRL_ACTA_LSB  = 8;
    localparam int CTRL_ACTB_LSB  = 10;
    localparam int CTRL_IRQEN_LSB = 12;
    localparam int CTRL_ROUTE_LSB = 16;

    // Flag register fields
    localparam int FLAG_MATCHA   = 0;
    localparam int FLAG_MATCHB   = 1;
    localparam int FLAG_OVF      = 2;
    localparam int FLAG_OCST_LSB = 8;

    // Reset values
    localparam logic [3:0]  RST_MODE   = 4'h0;
    localparam logic [2:0]  RST_CLKSEL = 3'h0;
    localparam logic [15:0] RST_COUNT  = 16'h0000;
    localparam logic [15:0] RST_CMP    = 16'h0000;
    localparam logic [7:0]  RST_TEMP   = 8'h00;
    localparam logic [31:0] RST_RDATA  = 32'h0000_0000;

    // Waveform mode codes
    localparam logic [3:0] MODE_NORMAL   = 4'h0;
    localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
    localparam logic [3:0] MODE_FAST8    = 4'h5;
    localparam logic [3:0] MODE_FAST9    = 4'h6;
    localparam logic [3:0] MODE_FAST10   = 4'h7;
    localparam logic [3:0] MODE_PFC_CMPA = 4'h9;
    localparam logic [3:0] MODE_PC_CMPA  = 4'hB;
    localparam logic [3:0] MODE_CTC_CAP  = 4'hC;
    localparam logic [3:0] MODE_FAST_A   = 4'hF;

    // Fixed counter limits
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] CNT_BOT   = 16'h0000;
    localparam logic [15:0] TOP_FIX8  = 16'h00FF;
    localparam logic [15:0] TOP_FIX9  = 16'h01FF;
    localparam logic [15:0] TOP_FIX10 = 16'h03FF;

    // Output action codes
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;

    localparam int NUM_CH = 2;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_RESP = 2'b10
    } t16oc_phase_t;

endpackage

// ---- t16oc_cpu.sv ----
`timescale 1ns/100ps
module t16oc_cpu (
    input  wire logic        sys_clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // Request held until pready is sampled high; no fixed wait assumed
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr16(input logic [7:0] hi, input logic [15:0] v);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, hi, {24'h0000_00, v[15:8]}, q, e);
        xfer(1'b1, hi - 8'h04, {24'h0000_00, v[7:0]}, q, e);
    endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top import t16oc_pkg::*; ;
    logic              sys_clk;
    logic              reset;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
    logic              timerTick;
    logic [2:0]        irqServiced;
    logic [2:0]        irqRequest;
    logic [NUM_CH-1:0] portData;
    logic [NUM_CH-1:0] portDir;
    logic [NUM_CH-1:0] compareOutputPin;
    logic [NUM_CH-1:0] compareOutputPinOe;
    logic [31:0]       q;
    logic              e;
    logic [15:0]       x;
    logic [1:0]        st;
    logic [1:0]        acts [5];
    int                errors;
    int                n_checks;
    int                seed;

    t16oc_top dut_u (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .timerTick(timerTick), .irqServiced(irqServiced),
        .irqRequest(irqRequest), .portData(portData), .portDir(portDir),
        .compareOutputPin(compareOutputPin), .compareOutputPinOe(compareOutputPinOe));
    t16oc_cpu cpu_u (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] w);
        n_checks++;
        if (s !== w) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, s, w);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cpu_u.xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] w);
        cpu_u.xfer(1'b0, a, 32'h0000_0000, q, e);
        chk(q, w);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            timerTick <= 1'b1;
            @(posedge sys_clk);
            timerTick <= 1'b0;
            @(posedge sys_clk);
        end
    endtask

    // Both channels share the action code; all irq enables and routes on
    function automatic logic [31:0] ctl(input logic [3:0] m, input logic [2:0] c,
                                        input logic [1:0] a);
        ctl = 32'h0003_7000 | {20'h0_0000, a, a, 1'b0, c, m};
    endfunction

    function automatic logic [1:0] nxt(input logic [1:0] s, input logic [1:0] a);
        nxt = (a == ACT_TOGGLE) ? ~s : (a == ACT_CLEAR) ? 2'h0 : (a == ACT_SET) ? 2'h3 : s;
    endfunction

    initial begin
        repeat (6000) @(posedge sys_clk);
        errors++;
        wrap_up();
    end

    initial begin
        seed = 32'h40f8_b3c1;
        reset = 1'b1;
        timerTick = 1'b0;
        irqServiced = 3'h0;
        portData = 2'h0;
        portDir = 2'h0;
        errors = 0;
        n_checks = 0;
        acts = '{ACT_SET, ACT_NONE, ACT_TOGGLE, ACT_CLEAR, ACT_TOGGLE};
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd(OFS_CTRL, 32'h0000_0000);
        rd(OFS_FLAGS, 32'h0000_0000);
        rd(8'h24, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        // Latch is loaded with count high (zero) before the compare high read
        x = 16'h1000 + 16'($random(seed) & 32'h0000_0FFF);
        cpu_u.wr16(OFS_CMPA_HI, x);
        rd(OFS_COUNT_LO, 32'h0000_0000);
        rd(OFS_CMPA_HI, {24'h0000_00, x[15:8]});
        rd(OFS_CMPA_LO, {24'h0000_00, x[7:0]});
        wr(OFS_CTRL, ctl(MODE_NORMAL, 3'h1, ACT_TOGGLE));
        cpu_u.wr16(OFS_COUNT_HI, x);
        tick(1);
        rd(OFS_FLAGS, 32'h0000_0000);
        cpu_u.wr16(OFS_COUNT_HI, x - 16'h0002);
        tick(3);
        chk({29'h0, irqRequest}, 32'h0000_0001);
        rd(OFS_FLAGS, 32'h0000_0101);
        irqServiced <= 3'h1;
        @(posedge sys_clk);
        irqServiced <= 3'h0;
        @(posedge sys_clk);
        rd(OFS_FLAGS, 32'h0000_0100);
        cpu_u.wr16(OFS_COUNT_HI, x - 16'h0001);
        tick(2);
        rd(OFS_FLAGS, 32'h0000_0001);
        wr(OFS_FLAGS, 32'h0000_0001);
        rd(OFS_FLAGS, 32'h0000_0000);
        st = 2'h0;
        foreach (acts[k]) begin
            portData <= 2'($random(seed));
            portDir <= 2'($random(seed));
            wr(OFS_CTRL, ctl(MODE_NORMAL, 3'h0, acts[k]));
            wr(OFS_FORCE, 32'h0000_0003);
            st = nxt(st, acts[k]);
            rd(OFS_FLAGS, {22'h0, st, 8'h00});
            chk(32'(compareOutputPin), 32'((acts[k] != ACT_NONE) ? st : portData));
            chk(32'(compareOutputPinOe), 32'(portDir));
        end
        wr(OFS_CTRL, ctl(MODE_FAST8, 3'h0, ACT_NONE));
        rd(OFS_FLAGS, {22'h0, st, 8'h00});
        wr(OFS_CTRL, ctl(MODE_NORMAL, 3'h1, ACT_NONE));
        cpu_u.wr16(OFS_COUNT_HI, CNT_MAX);
        tick(2);
        chk({29'h0, irqRequest}, 32'h0000_0006);
        rd(OFS_FLAGS, {22'h0, st, 8'h06});
        rd(OFS_COUNT_LO, 32'h0000_0001);
        rd(OFS_COUNT_HI, 32'h0000_0000);
        wr(OFS_CTRL, ctl(MODE_NORMAL, 3'h0, ACT_NONE));
        tick(3);
        rd(OFS_COUNT_LO, 32'h0000_0001);
        // PWM: new compare B waits in the buffer until TOP (0x00FF)
        wr(OFS_FLAGS, 32'h0000_0007);
        wr(OFS_CTRL, ctl(MODE_FAST8, 3'h1, ACT_NONE));
        cpu_u.wr16(OFS_CMPB_HI, 16'h0080);
        rd(OFS_CMPB_LO, 32'h0000_0080);
        tick(254);
        rd(OFS_FLAGS, {22'h0, st, 8'h00});
        tick(130);
        rd(OFS_FLAGS, {22'h0, st, 8'h06});
        wrap_up();
    end
endmodule
